/* core/scs_map.vh */
// Purpose: constants of the sensor command sequencer
// Assumes: included by its bare name
// Notes: byte offsets on the AXI4-Lite slave
`ifndef SCS_MAP_VH
`define SCS_MAP_VH
`define SCS_OFF_CMD 8'h00
`define SCS_OFF_PIN 8'h04
`define SCS_OFF_PRB 8'h08
`define SCS_OFF_RSP 8'h0c
`define SCS_OFF_KEY 8'h10
`define SCS_OFF_SADR 8'h14
`define SCS_OFF_STAT 8'h18
`define SCS_OFF_MEAS 8'h1c
`define SCS_OFF_OVF 8'h20
`define SCS_PAR_CHANNEL_ENABLE_LIST 5'h01
`define SCS_PAR_PRATE 5'h0a
`define SCS_PAR_ARATE 5'h0b
`define SCS_PAR_WAKE 5'h0c
`define SCS_CMD_NOP 8'h00
`define SCS_CMD_RESET 8'h01
`define SCS_CMD_SADR 8'h02
`define SCS_CMD_PFORCE 8'h05
`define SCS_CMD_AFORCE 8'h06
`define SCS_CMD_BFORCE 8'h07
`define SCS_CMD_PHALT 8'h09
`define SCS_CMD_AHALT 8'h0a
`define SCS_CMD_BHALT 8'h0b
`define SCS_CMD_PLOOP 8'h0d
`define SCS_CMD_ALOOP 8'h0e
`define SCS_CMD_BLOOP 8'h0f
`define SCS_ERR_INVALID 8'h80
`define SCS_ERR_OVF_BASE 8'h88
`define SCS_ERR_OVF_AMB 8'h8c
`define SCS_KEY_UNLOCK 8'h17
`define SCS_SADR_RESET 7'h5a
`define SCS_TICK_NS 32
`define SCS_CLK_NS 10
`define SCS_RESP_OKAY 2'b00
`define SCS_RESP_SLVERR 2'b10
`endif

/* core/scs_sequencer.v */
// Purpose: command interpreter and measurement sequencer
// Assumes: AXI4-Lite master, one write and one read under way at a time
// Notes: channel conversion is done outside via meas_start/meas_done
//
// Behaviour
// - Register access never wakes sequencer, except command
// - Zero wake interval means forced mode only
// - Forced mode wakes only on command write
// - Nonzero interval wakes periodically
// - Each timed wake advances the counters of looping groups only
// - Proximity channels measured 1, 2, 3 in order
// - Ambient channels visible, infrared, extra order
// - Rate zero disables group, one every wake
// - Proximity group completes before ambient group
// - Sleep after scheduled measurements until next wake
// - Command write wakes sequencer to process it
// - Success reply: zero nibble, circular counter
// - Errors set nonzero upper reply nibble
// - Read command copies parameter to readback
// - Write command stores input, copies readback
// - Mask command ANDs parameter with input
// - Merge command ORs parameter with input
// - No-operation clears reply to zero
// - Reset command resets control; address change
// - Single commands run one group pass
// - Halt and loop commands per group
// - Invalid setting error sticks until no-operation or reset command
// - Overflow loads per-channel overflow code
//
// The implementer's own choices: the register offsets and the AXI4-Lite register port.
`include "scs_map.vh"
module scs_sequencer #(
	parameter TICK_CYCLES = (`SCS_TICK_NS + `SCS_CLK_NS - 1) / `SCS_CLK_NS
)(
	input wire aclk,
	input wire aresetn,
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	output reg [2:0] meas_channel,
	output reg meas_start,
	input wire meas_done,
	input wire meas_overflow,
	output reg awake
);
	localparam ST_SLEEP = 3'd0;
	localparam ST_EXEC = 3'd1;
	localparam ST_PICK = 3'd2;
	localparam ST_MEAS = 3'd3;
	localparam ST_WAIT = 3'd4;
	localparam ST_DONE = 3'd5;

	reg [7:0] param_ram [0:31];
	reg [7:0] cmd_q;
	reg cmd_pend_q;
	reg [7:0] pin_q;
	reg [7:0] prb_q;
	reg [7:0] rsp_q;
	reg [7:0] key_q;
	reg [6:0] sadr_q;
	reg [2:0] st_q;
	reg [15:0] tick_q;
	reg [7:0] wake_q;
	reg [7:0] pcnt_q;
	reg [7:0] acnt_q;
	reg prun_q;
	reg arun_q;
	reg [5:0] todo_q;
	reg cmd_run_q;
	reg [7:0] ovf_q;
	reg aw_got_q;
	reg w_got_q;
	reg [7:0] awaddr_q;
	reg [31:0] wdata_q;
	reg [3:0] wstrb_q;
	wire [7:0] wake_int = param_ram[`SCS_PAR_WAKE];
	wire [7:0] chl = param_ram[`SCS_PAR_CHANNEL_ENABLE_LIST];
	wire [7:0] prate = param_ram[`SCS_PAR_PRATE];
	wire [7:0] arate = param_ram[`SCS_PAR_ARATE];
	wire [4:0] pidx = cmd_q[4:0];
	wire [7:0] pval = param_ram[pidx];
	wire [7:0] pnew = cmd_q[6:5] == 2'b01 ? pin_q :
		cmd_q[6:5] == 2'b10 ? pval & pin_q :
		pval | pin_q;
	wire wr_fire = aw_got_q && w_got_q && !s_axi_bvalid;
	wire wr_cmd = wr_fire && awaddr_q == `SCS_OFF_CMD && wstrb_q[0];
	wire [5:0] pmask = {3'b000, chl[2:0]};
	wire [5:0] amask = {chl[6:4], 3'b000};
	wire [3:0] cnt_next = rsp_q[3:0] + 4'h1;
	wire tick_end = tick_q >= TICK_CYCLES[15:0] - 16'h0001;
	wire wake_due = wake_int != 8'h00 && tick_end &&
		wake_q >= wake_int - 8'h01;
	wire pexp = prun_q && prate != 8'h00 && pcnt_q <= 8'h01;
	wire aexp = arun_q && arate != 8'h00 && acnt_q <= 8'h01;
	// Ambient codes leave a gap after the proximity ones
	wire [7:0] ovf_code = meas_channel < 3'd3 ?
		`SCS_ERR_OVF_BASE + {5'h00, meas_channel} :
		`SCS_ERR_OVF_AMB + {5'h00, meas_channel} - 8'h03;
	reg [2:0] first_ch;
	integer i;

	always @*
	begin
		first_ch = 3'd7;
		for (i = 5; i >= 0; i = i - 1)
			if (todo_q[i])
				first_ch = i[2:0];
	end

	assign s_axi_awready = !aw_got_q;
	assign s_axi_wready = !w_got_q;
	assign s_axi_arready = !s_axi_rvalid;

	// Write channel: address and data taken in either order
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_got_q <= 1'b0;
			w_got_q <= 1'b0;
			awaddr_q <= 8'h00;
			wdata_q <= 32'h0;
			wstrb_q <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `SCS_RESP_OKAY;
		end
		else
		begin
			if (s_axi_awvalid && !aw_got_q)
			begin
				aw_got_q <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && !w_got_q)
			begin
				w_got_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			if (wr_fire)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (awaddr_q == `SCS_OFF_CMD ||
					awaddr_q == `SCS_OFF_PIN ||
					awaddr_q == `SCS_OFF_KEY) ?
					`SCS_RESP_OKAY : `SCS_RESP_SLVERR;
			end
			else if (s_axi_bvalid && s_axi_bready)
			begin
				s_axi_bvalid <= 1'b0;
				aw_got_q <= 1'b0;
				w_got_q <= 1'b0;
			end
		end
	end

	// Reads only look at state, never wake the sequencer
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= `SCS_RESP_OKAY;
		end
		else if (s_axi_arvalid && !s_axi_rvalid)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= `SCS_RESP_OKAY;
			case (s_axi_araddr)
			`SCS_OFF_CMD: s_axi_rdata <= {24'h0, cmd_q};
			`SCS_OFF_PIN: s_axi_rdata <= {24'h0, pin_q};
			`SCS_OFF_PRB: s_axi_rdata <= {24'h0, prb_q};
			`SCS_OFF_RSP: s_axi_rdata <= {24'h0, rsp_q};
			`SCS_OFF_KEY: s_axi_rdata <= {24'h0, key_q};
			`SCS_OFF_SADR: s_axi_rdata <= {25'h0, sadr_q};
			`SCS_OFF_STAT: s_axi_rdata <= {24'h0, 1'b0, st_q,
				cmd_pend_q, arun_q, prun_q, awake};
			`SCS_OFF_MEAS: s_axi_rdata <= {24'h0, wake_int};
			`SCS_OFF_OVF: s_axi_rdata <= {24'h0, ovf_q};
			default:
			begin
				s_axi_rdata <= 32'h0;
				s_axi_rresp <= `SCS_RESP_SLVERR;
			end
			endcase
		end
		else if (s_axi_rvalid && s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	// Sequencer; command register write is its only host wake source
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			cmd_q <= 8'h00;
			cmd_pend_q <= 1'b0;
			pin_q <= 8'h00;
			prb_q <= 8'h00;
			rsp_q <= 8'h00;
			key_q <= 8'h00;
			sadr_q <= `SCS_SADR_RESET;
			st_q <= ST_SLEEP;
			tick_q <= 16'h0;
			wake_q <= 8'h00;
			pcnt_q <= 8'h00;
			acnt_q <= 8'h00;
			prun_q <= 1'b0;
			arun_q <= 1'b0;
			todo_q <= 6'h00;
			cmd_run_q <= 1'b0;
			ovf_q <= 8'h00;
			meas_start <= 1'b0;
			meas_channel <= 3'd0;
			awake <= 1'b0;
			for (i = 0; i < 32; i = i + 1)
				param_ram[i] <= 8'h00;
		end
		else
		begin
			meas_start <= 1'b0;
			if (wr_fire && awaddr_q == `SCS_OFF_PIN && wstrb_q[0])
				pin_q <= wdata_q[7:0];
			if (wr_fire && awaddr_q == `SCS_OFF_KEY && wstrb_q[0])
				key_q <= wdata_q[7:0];
			// Command taken only while no command is pending
			if (wr_cmd && !cmd_pend_q)
			begin
				cmd_q <= wdata_q[7:0];
				cmd_pend_q <= 1'b1;
			end
			// Wake interval timebase; zero interval stops it
			if (wake_int == 8'h00)
			begin
				tick_q <= 16'h0;
				wake_q <= 8'h00;
			end
			else if (tick_end)
			begin
				tick_q <= 16'h0;
				wake_q <= wake_due ? 8'h00 : wake_q + 8'h01;
			end
			else
				tick_q <= tick_q + 16'h0001;
			case (st_q)
			ST_SLEEP:
			begin
				awake <= 1'b0;
				if (cmd_pend_q)
				begin
					st_q <= ST_EXEC;
					awake <= 1'b1;
				end
				else if (wake_due)
				begin
					awake <= 1'b1;
					cmd_run_q <= 1'b0;
					// Counters reload on expiry or when zero
					if (prun_q)
						pcnt_q <= pexp ? prate : pcnt_q - 8'h01;
					if (arun_q)
						acnt_q <= aexp ? arate : acnt_q - 8'h01;
					todo_q <= (pexp ? pmask : 6'h00) |
						(aexp ? amask : 6'h00);
					st_q <= ST_PICK;
				end
			end
			ST_EXEC:
			begin
				cmd_pend_q <= 1'b0;
				st_q <= ST_DONE;
				cmd_run_q <= 1'b1;
				if (cmd_q[7])
				begin
					// Parameter ops, index in the low five bits
					prb_q <= cmd_q[6:5] == 2'b00 ? pval : pnew;
					if (cmd_q[6:5] != 2'b00)
						param_ram[pidx] <= pnew;
				end
				else
				begin
					case (cmd_q)
					`SCS_CMD_NOP:
					begin
						rsp_q <= 8'h00;
						cmd_run_q <= 1'b0;
					end
					`SCS_CMD_RESET:
					begin
						// Control state back to reset values
						rsp_q <= 8'h00;
						prun_q <= 1'b0;
						arun_q <= 1'b0;
						pin_q <= 8'h00;
						prb_q <= 8'h00;
						key_q <= 8'h00;
						ovf_q <= 8'h00;
						sadr_q <= `SCS_SADR_RESET;
						cmd_run_q <= 1'b0;
						for (i = 0; i < 32; i = i + 1)
							param_ram[i] <= 8'h00;
					end
					`SCS_CMD_SADR: sadr_q <= pin_q[6:0];
					`SCS_CMD_PFORCE, `SCS_CMD_AFORCE, `SCS_CMD_BFORCE:
					begin
						// Bit 0 selects proximity, bit 1 ambient
						todo_q <= (cmd_q[0] ? pmask : 6'h00) |
							(cmd_q[1] ? amask : 6'h00);
						st_q <= ST_PICK;
					end
					`SCS_CMD_PHALT, `SCS_CMD_AHALT, `SCS_CMD_BHALT,
					`SCS_CMD_PLOOP, `SCS_CMD_ALOOP, `SCS_CMD_BLOOP:
					begin
						// Bit 2 tells loop from halt
						if (cmd_q[0])
						begin
							prun_q <= cmd_q[2];
							pcnt_q <= 8'h01;
						end
						if (cmd_q[1])
						begin
							arun_q <= cmd_q[2];
							acnt_q <= 8'h01;
						end
						// Looping needs a nonzero wake interval
						if (cmd_q[2] && wake_int == 8'h00)
						begin
							cmd_run_q <= 1'b0;
							rsp_q <= `SCS_ERR_INVALID;
						end
					end
					default: cmd_run_q <= 1'b1;
					endcase
				end
			end
			ST_PICK:
			begin
				// Lowest bit first: prox 1..3 then ambient
				if (todo_q == 6'h00)
					st_q <= ST_DONE;
				else
				begin
					meas_channel <= first_ch;
					meas_start <= 1'b1;
					st_q <= ST_WAIT;
				end
			end
			ST_WAIT:
			begin
				if (meas_done)
				begin
					todo_q[meas_channel] <= 1'b0;
					if (meas_overflow)
					begin
						ovf_q <= ovf_code;
						if (!rsp_q[7])
							rsp_q <= ovf_code;
						cmd_run_q <= 1'b0;
					end
					st_q <= ST_PICK;
				end
			end
			ST_DONE:
			begin
				// Error codes stand until no-operation or reset command
				if (cmd_run_q && !rsp_q[7])
					rsp_q <= {4'h0, cnt_next};
				cmd_run_q <= 1'b0;
				todo_q <= 6'h00;
				st_q <= ST_SLEEP;
				awake <= 1'b0;
			end
			default: st_q <= ST_SLEEP;
			endcase
		end
	end
endmodule // scs_sequencer

/* tb/scs_conv_model.sv */
// Purpose: converter model answering conversion requests
// Assumes: one conversion at a time, started by a pulse
// Notes: answers quickly and slowly by turns
module scs_conv_model(
	input wire aclk,
	input wire aresetn,
	input wire meas_start,
	input wire ovf_en,
	output logic meas_done,
	output wire meas_overflow
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] cnt_q;
	logic busy_q;
	logic slow_q;
	always @(posedge aclk)
		if (!aresetn)
		begin
			busy_q <= 0;
			cnt_q <= 0;
			slow_q <= 0;
			meas_done <= 0;
		end
		else
		begin
			meas_done <= 0;
			if (meas_start)
			begin
				busy_q <= 1;
				cnt_q <= slow_q ? 4'h6 : 4'h1;
				slow_q <= !slow_q;
			end
			else if (busy_q && cnt_q == 0)
			begin
				meas_done <= 1;
				busy_q <= 0;
			end
			else if (busy_q)
				cnt_q <= cnt_q - 1;
		end
	// Flag is only valid with done; follows the count bit otherwise so it is never trusted
	assign meas_overflow = meas_done ? ovf_en : cnt_q[0];
endmodule // scs_conv_model

/* tb/scs_seq_chk.sv */
// Purpose: port checker for the sequencer
// Assumes: one clock, synchronous active-low reset
// Notes: bound at the foot of this file
module scs_seq_chk(
	input wire aclk,
	input wire aresetn,
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire [1:0] s_axi_bresp,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire [2:0] meas_channel,
	input wire meas_start,
	input wire awake
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	logic [2:0] last_q;
	logic run_q;
	// Order is judged within one wake only
	always @(posedge aclk)
		if (!aresetn || !awake)
		begin
			run_q <= 0;
			last_q <= 0;
		end
		else if (meas_start)
		begin
			run_q <= 1;
			last_q <= meas_channel;
		end
	sequence cmd_wr_s;
		s_axi_awvalid && s_axi_awready && s_axi_awaddr == 8'h00 &&
			s_axi_wvalid && s_axi_wready && !awake;
	endsequence
	sequence pulse_s;
		meas_start ##1 !meas_start;
	endsequence
	chk_cmd_wakes: assert property (cmd_wr_s |-> ##[1:4] awake)
		else $error("command write did not wake");
	chk_start_awake: assert property (meas_start |-> awake)
		else $error("conversion while asleep");
	chk_start_pulse: assert property (meas_start |-> pulse_s)
		else $error("start longer than one cycle");
	chk_chan_order: assert property (meas_start && run_q |-> meas_channel > last_q)
		else $error("channel order broken");
	chk_chan_range: assert property (meas_start |-> meas_channel <= 3'h5)
		else $error("channel out of range");
	chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	chk_ar_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read not answered");
endmodule // scs_seq_chk
bind scs_sequencer scs_seq_chk i_chk(.*);

/* tb/sensor_command_sequencer_tb.sv */
// Purpose: self-checking bench for the sequencer
// Assumes: bus master tasks, converter model
// Notes: wake unit shortened to two cycles
module sensor_command_sequencer_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic aclk, aresetn, ovf_en;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_rready;
	logic [31:0] s_axi_wdata, d;
	logic [3:0] s_axi_wstrb;
	logic [1:0] r;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid;
	wire s_axi_arready, s_axi_rvalid;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire [2:0] meas_channel;
	wire meas_start, meas_done, meas_overflow, awake;
	int err_total, total_checks, cnt;
	logic [2:0] log_q[$];
	scs_sequencer #(.TICK_CYCLES(2)) i_dut(.*);
	scs_conv_model i_conv(.*);
	initial
	begin
		aclk = 0;
		forever #5 aclk = ~aclk;
	end
	always @(posedge aclk)
		if (meas_start)
			log_q.push_back(meas_channel);
	task summarize;
		if (err_total == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task chk(input logic [39:0] s, input logic [39:0] e);
		total_checks++;
		if (s !== e)
		begin
			err_total++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task tmo(input int n);
		if (n >= 60)
		begin
			err_total++;
			summarize;
		end
	endtask
	task wr(input [7:0] a, input [31:0] v, output [1:0] q);
		int n;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		// Response ready raised late so the hold path is exercised
		for (n = 0; n < 60; n++)
		begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 0;
			if (s_axi_wready)
				s_axi_wvalid <= 0;
			if (s_axi_bvalid && s_axi_bready)
				break;
			if (s_axi_bvalid)
				s_axi_bready <= 1;
		end
		q = s_axi_bresp;
		s_axi_bready <= 0;
		tmo(n);
	endtask
	task rd(input [7:0] a, output [31:0] v, output [1:0] q);
		int n;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		for (n = 0; n < 60; n++)
		begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 0;
			if (s_axi_rvalid && s_axi_rready)
				break;
			if (s_axi_rvalid)
				s_axi_rready <= 1;
		end
		v = s_axi_rdata;
		q = s_axi_rresp;
		s_axi_rready <= 0;
		tmo(n);
	endtask
	// Polls the reply until it shows the expected value, then compares
	task cmd(input [7:0] c, input [7:0] e);
		int n;
		wr(8'h00, {24'h0, c}, r);
		for (n = 0; n < 60; n++)
		begin
			rd(8'h0c, d, r);
			if (d === {24'h0, e})
				break;
		end
		chk(d, e);
	endtask
	task pcmd(input [7:0] c, input [7:0] v, input [7:0] e);
		wr(8'h04, {24'h0, v}, r);
		cnt++;
		cmd(c, cnt[3:0]);
		rd(8'h08, d, r);
		chk(d, e);
	endtask
	initial
	begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 0;
		{s_axi_arvalid, s_axi_rready, ovf_en} = 0;
		s_axi_awaddr = 0;
		s_axi_araddr = 0;
		s_axi_wdata = 0;
		s_axi_wstrb = 4'hf;
		aresetn = 0;
		repeat (5) @(posedge aclk);
		aresetn <= 1;
		wr(8'h10, 32'h17, r);
		chk(awake, 0);
		rd(8'h3c, d, r);
		chk({d, r}, {32'h0, 2'b10});
		wr(8'h14, 32'h11, r);
		chk(r, 2'b10);
		pcmd(8'ha1, 8'h77, 8'h77);
		pcmd(8'hc1, 8'h35, 8'h35);
		pcmd(8'he1, 8'h42, 8'h77);
		pcmd(8'h81, 8'h00, 8'h77);
		for (int k = 5; k < 8; k++)
		begin
			log_q.delete();
			cnt++;
			cmd(k, cnt[3:0]);
			chk(log_q.size(), k == 7 ? 6 : 3);
			foreach (log_q[i]) chk(log_q[i], i + (k == 6 ? 3 : 0));
		end
		cnt++;
		cmd(8'h03, cnt[3:0]);
		rd(8'h08, d, r);
		chk(d, 32'h77);
		log_q.delete();
		repeat (50) @(posedge aclk);
		chk(log_q.size(), 0);
		pcmd(8'ha1, 8'h01, 8'h01);
		ovf_en <= 1;
		cmd(8'h05, 8'h88);
		ovf_en <= 0;
		cmd(8'h00, 8'h00);
		cnt = 0;
		pcmd(8'ha1, 8'h40, 8'h40);
		ovf_en <= 1;
		cmd(8'h06, 8'h8e);
		rd(8'h20, d, r);
		chk(d, 32'h8e);
		ovf_en <= 0;
		cmd(8'h00, 8'h00);
		cmd(8'h0f, 8'h80);
		rd(8'h0c, d, r);
		chk(d, 32'h80);
		cmd(8'h00, 8'h00);
		cnt = 0;
		pcmd(8'ha1, 8'h01, 8'h01);
		pcmd(8'haa, 8'h01, 8'h01);
		pcmd(8'hac, 8'h02, 8'h02);
		log_q.delete();
		cnt++;
		cmd(8'h0d, cnt[3:0]);
		repeat (100) @(posedge aclk);
		chk(log_q.size() > 2, 1);
		foreach (log_q[i]) chk(log_q[i], 0);
		cnt++;
		cmd(8'h09, cnt[3:0]);
		log_q.delete();
		repeat (60) @(posedge aclk);
		chk(log_q.size(), 0);
		wr(8'h04, 32'h33, r);
		cnt++;
		cmd(8'h02, cnt[3:0]);
		rd(8'h14, d, r);
		chk(d, 32'h33);
		cmd(8'h01, 8'h00);
		rd(8'h14, d, r);
		chk(d, 32'h5a);
		cnt = 0;
		pcmd(8'h81, 8'h00, 8'h00);
		summarize;
	end
endmodule // sensor_command_sequencer_tb
